// >>> src/sspx_top.sv
`timescale 1ns/1ns
`default_nettype none
module sspx_top
   import sspx_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   input  wire logic        i_timer_tick,
   input  wire logic        i_byte_done,
   input  wire logic        i_byte_is_data,
   input  wire logic        i_byte_rx,
   input  wire logic        i_buf_read,
   input  wire logic        i_addr_match,
   input  wire logic        i_rw_bit,
   input  wire logic        i_nack,
   input  wire logic        i_addr_update,
   output logic             o_pins_to_port,
   output logic             o_spi_mode,
   output logic             o_i2c_mode,
   output logic             o_master,
   output logic             o_sample_at_end,
   output logic             o_launch_rising,
   output logic             o_slew_ctrl_en,
   output logic             o_smbus_levels,
   output logic             o_bit_launch,
   output logic             o_bit_sample,
   output logic             o_irq
);
   typedef struct packed {
      logic [1:0]       scl_sync;
      logic [1:0]       sda_sync;
      logic             scl_prev;
      logic             sda_prev;
      logic [7:0]       status;
      logic [7:0]       control;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic             ph_valid;
      logic             ph_write;
      logic [31:0]      ph_addr;
      logic [31:0]      rdata;
   } sspx_state_t;

   sspx_state_t r;
   sspx_state_t next_r;

   function automatic logic is_spi(input logic [3:0] mode);
      return mode <= MODE_SPI_S_FREE;
   endfunction

   function automatic logic is_i2c(input logic [3:0] mode);
      return (mode == MODE_I2C_S7) || (mode == MODE_I2C_S10)
          || (mode == MODE_I2C_M) || (mode == MODE_I2C_FW)
          || (mode == MODE_I2C_FW7) || (mode == MODE_I2C_FW10);
   endfunction

   function automatic logic is_master(input logic [3:0] mode);
      return (mode <= MODE_SPI_M_TMR) || (mode == MODE_I2C_M)
          || (mode == MODE_I2C_FW) || (mode == MODE_I2C_FW7)
          || (mode == MODE_I2C_FW10);
   endfunction

   // Data line edge while the clock line stays high; rising means stop
   function automatic logic line_cond(input logic scl_now,
                                      input logic scl_was,
                                      input logic sda_now,
                                      input logic sda_was,
                                      input logic rising);
      return scl_now && scl_was && (sda_was == !rising) && (sda_now == rising);
   endfunction

   // Register select, one flag per mapped word
   typedef struct packed {
      logic status;
      logic control;
      logic irq_stat;
      logic irq_clr;
      logic irq_en;
   } sspx_sel_t;

   // Address decode shared by read and write paths
   function automatic sspx_sel_t reg_decode(input logic [31:0] addr);
      sspx_sel_t sel;
      sel = '0;
      sel.status = (addr == ADDR_STATUS);
      sel.control = (addr == ADDR_CONTROL);
      sel.irq_stat = (addr == ADDR_IRQ_STAT);
      sel.irq_clr = (addr == ADDR_IRQ_CLR);
      sel.irq_en = (addr == ADDR_IRQ_EN);
      return sel;
   endfunction

   logic [3:0]       mode;
   logic             enabled;
   logic             spi_on;
   logic             i2c_on;
   logic             spi_master;
   logic             bus_start;
   logic             bus_stop;
   logic             accept;
   logic             wr_now;
   logic [IRQ_W-1:0] events;
   logic [31:0]      rd_value;
   sspx_sel_t        rd_sel;
   sspx_sel_t        wr_sel;

   sspx_rate_if rate_bus ();

   assign mode = r.control[CT_MODE_LSB +: 4];
   assign enabled = r.control[CT_ENABLE];
   assign spi_on = enabled && is_spi(mode);
   assign i2c_on = enabled && is_i2c(mode);
   assign spi_master = spi_on && is_master(mode);

   // start: data falls while clock high
   assign bus_start = i2c_on && line_cond(r.scl_sync[1], r.scl_prev,
                                          r.sda_sync[1], r.sda_prev, 1'b0);
   // stop: data rises while clock high
   assign bus_stop = i2c_on && line_cond(r.scl_sync[1], r.scl_prev,
                                         r.sda_sync[1], r.sda_prev, 1'b1);

   always_comb
   begin
      events = '0;
      events[IRQ_START] = bus_start;
      events[IRQ_STOP] = bus_stop;
      events[IRQ_RX] = enabled && i_byte_rx;
      events[IRQ_ADDR] = i2c_on && i_addr_match;
   end

   // Bus address phase capture
   assign accept = i_hsel && i_htrans[1] && i_hready
                && (i_hsize == HSIZE_WORD);
   assign wr_now = r.ph_valid && r.ph_write;
   assign wr_sel = reg_decode(r.ph_addr);

   // Read value chosen in the address phase
   always_comb
   begin
      rd_sel = reg_decode(i_haddr);
      rd_value = 32'h0000_0000;
      if (rd_sel.status)
      begin
         rd_value[7:0] = r.status;
      end
      if (rd_sel.control)
      begin
         rd_value[7:0] = r.control;
      end
      if (rd_sel.irq_stat)
      begin
         rd_value[IRQ_W-1:0] = r.irq_stat;
      end
      if (rd_sel.irq_en)
      begin
         rd_value[IRQ_W-1:0] = r.irq_en;
      end
   end

   always_comb
   begin
      next_r = r;

      // Pin synchronisers and edge history
      next_r.scl_sync = {r.scl_sync[0], i_scl};
      next_r.sda_sync = {r.sda_sync[0], i_sda};
      next_r.scl_prev = r.scl_sync[1];
      next_r.sda_prev = r.sda_sync[1];

      // Bus slave pipeline
      next_r.ph_valid = accept;
      next_r.ph_write = i_hwrite;
      next_r.ph_addr = i_haddr;
      next_r.rdata = (accept && !i_hwrite) ? rd_value : 32'h0000_0000;

      if (bus_start)
      begin
         next_r.status[ST_START] = 1'b1;
         next_r.status[ST_STOP] = 1'b0;
      end
      if (bus_stop)
      begin
         next_r.status[ST_STOP] = 1'b1;
         next_r.status[ST_START] = 1'b0;
      end

      if (i2c_on && i_byte_done)
      begin
         next_r.status[ST_DATA] = i_byte_is_data;
      end

      if (i2c_on && (bus_start || bus_stop || i_nack))
      begin
         next_r.status[ST_READ] = 1'b0;
      end
      else if (i2c_on && i_addr_match)
      begin
         next_r.status[ST_READ] = i_rw_bit;
      end

      next_r.status[ST_UPDATE] = i2c_on && i_addr_update;

      next_r.status[ST_FULL] = (r.status[ST_FULL] && !i_buf_read)
                            || (enabled && i_byte_rx);

      if (!enabled)
      begin
         next_r.status[ST_START] = 1'b0;
         next_r.status[ST_STOP] = 1'b0;
      end

      // Sticky events, set beats clear
      next_r.irq_stat = r.irq_stat | events;

      if (wr_now && wr_sel.status)
      begin
         next_r.status = (next_r.status & ~ST_WR_MASK)
                       | (i_hwdata[7:0] & ST_WR_MASK);
      end
      if (wr_now && wr_sel.control)
      begin
         next_r.control = i_hwdata[7:0] & CT_WR_MASK;
      end
      // Clear by ones, a new event still wins
      if (wr_now && wr_sel.irq_clr)
      begin
         next_r.irq_stat = (r.irq_stat & ~i_hwdata[IRQ_W-1:0])
                         | events;
      end
      if (wr_now && wr_sel.irq_en)
      begin
         next_r.irq_en = i_hwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= '0;
         // Lines idle high, so release shows no false edge
         r.scl_sync <= '1;
         r.sda_sync <= '1;
         r.scl_prev <= '1;
         r.sda_prev <= '1;
         r.status <= ST_RESET;
         r.control <= CT_RESET;
         r.irq_stat <= IRQ_RESET;
         r.irq_en <= IRQ_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Bit time generator for SPI master
   assign rate_bus.run = spi_master;
   assign rate_bus.rate_sel = mode[1:0];
   assign rate_bus.at_end = spi_master && r.status[ST_SAMPLE];
   assign rate_bus.timer_tick = i_timer_tick;

   sspx_rate_gen u_rate
   (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .rate    (rate_bus.gen)
   );

   assign o_bit_launch = rate_bus.launch;
   assign o_bit_sample = rate_bus.sample;

   // Bus answers
   assign o_hreadyout = 1'b1;
   assign o_hresp = HRESP_OKAY;
   assign o_hrdata = r.rdata;

   assign o_pins_to_port = enabled;
   assign o_spi_mode = spi_on;
   assign o_i2c_mode = i2c_on;
   assign o_master = enabled && is_master(mode);

   assign o_sample_at_end = rate_bus.at_end;
   assign o_launch_rising = spi_on
                         && (r.status[ST_EDGE] ^ r.control[CT_POLARITY]);
   assign o_slew_ctrl_en = i2c_on && !r.status[ST_SAMPLE];
   assign o_smbus_levels = i2c_on && r.status[ST_EDGE];

   // Interrupt level
   assign o_irq = |(r.irq_stat & r.irq_en);
endmodule
`default_nettype wire

// >>> common/sspx_pkg.sv
`default_nettype none
package sspx_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_STATUS   = 32'h0000_0094;
   localparam logic [31:0] ADDR_CONTROL  = 32'h0000_0098;
   localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_009C;
   localparam logic [31:0] ADDR_IRQ_CLR  = 32'h0000_00A0;
   localparam logic [31:0] ADDR_IRQ_EN   = 32'h0000_00A4;
   // Status bit positions
   localparam int ST_SAMPLE  = 7;
   localparam int ST_EDGE    = 6;
   localparam int ST_DATA    = 5;
   localparam int ST_STOP    = 4;
   localparam int ST_START   = 3;
   localparam int ST_READ    = 2;
   localparam int ST_UPDATE  = 1;
   localparam int ST_FULL    = 0;
   localparam logic [7:0] ST_WR_MASK = 8'hC0;
   localparam logic [7:0] ST_RESET   = 8'h00;
   // Control bit positions
   localparam int CT_ENABLE   = 5;
   localparam int CT_POLARITY = 4;
   localparam int CT_MODE_LSB = 0;
   localparam logic [7:0] CT_WR_MASK = 8'h3F;
   localparam logic [7:0] CT_RESET   = 8'h00;
   // Interrupt status layout
   localparam int IRQ_W     = 4;
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP  = 1;
   localparam int IRQ_RX    = 2;
   localparam int IRQ_ADDR  = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   // Mode codes of port_mode_select
   localparam logic [3:0] MODE_SPI_M_DIV4  = 4'h0;
   localparam logic [3:0] MODE_SPI_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_SPI_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_SPI_M_TMR   = 4'h3;
   localparam logic [3:0] MODE_SPI_S_SEL   = 4'h4;
   localparam logic [3:0] MODE_SPI_S_FREE  = 4'h5;
   localparam logic [3:0] MODE_I2C_S7      = 4'h6;
   localparam logic [3:0] MODE_I2C_S10     = 4'h7;
   localparam logic [3:0] MODE_I2C_M       = 4'h8;
   localparam logic [3:0] MODE_I2C_FW      = 4'hB;
   localparam logic [3:0] MODE_I2C_FW7     = 4'hE;
   localparam logic [3:0] MODE_I2C_FW10    = 4'hF;
   // Bit time rate generator: last count of each divider
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] LAST_DIV4  = 6'h03;
   localparam logic [CNT_W-1:0] LAST_DIV16 = 6'h0F;
   localparam logic [CNT_W-1:0] LAST_DIV64 = 6'h3F;
   localparam logic [CNT_W-1:0] LAST_TMR   = 6'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;
   // Bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;
endpackage
`default_nettype wire

// >>> common/sspx_rate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sspx_rate_if;
   import sspx_pkg::*;
   logic             run;
   logic [1:0]       rate_sel;
   logic             at_end;
   logic             timer_tick;
   logic             launch;
   logic             sample;
   modport gen
   (
      input  run,
      input  rate_sel,
      input  at_end,
      input  timer_tick,
      output launch,
      output sample
   );
   modport user
   (
      output run,
      output rate_sel,
      output at_end,
      output timer_tick,
      input  launch,
      input  sample
   );
endinterface
`default_nettype wire

// >>> src/sspx_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
module sspx_rate_gen
   import sspx_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_rst,
   sspx_rate_if.gen  rate
);
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             launch;
      logic             sample;
   } sspx_rate_state_t;

   sspx_rate_state_t r;
   sspx_rate_state_t next_r;
   logic [CNT_W-1:0] last;
   logic [CNT_W-1:0] mid;
   logic             step;

   // Bit time length per rate select
   always_comb
   begin
      unique case (rate.rate_sel)
         2'h0: last = LAST_DIV4;
         2'h1: last = LAST_DIV16;
         2'h2: last = LAST_DIV64;
         2'h3: last = LAST_TMR;
      endcase
      mid = last >> 1;
      step = (rate.rate_sel == 2'h3) ? rate.timer_tick : 1'b1;
   end

   always_comb
   begin
      next_r = r;
      next_r.launch = 1'b0;
      next_r.sample = 1'b0;
      if (!rate.run)
      begin
         next_r.count = CNT_ZERO;
      end
      else if (step)
      begin
         next_r.launch = (r.count == CNT_ZERO);
         next_r.sample = rate.at_end ? (r.count == last) : (r.count == mid);
         next_r.count = (r.count == last) ? CNT_ZERO : r.count + 6'h01;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         r <= '0;
      else
         r <= next_r;
   end

   assign rate.launch = r.launch;
   assign rate.sample = r.sample;
endmodule
`default_nettype wire

// >>> testbench/sspx_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module sspx_top_props
   import sspx_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic o_pins_to_port,
   input wire logic o_spi_mode,
   input wire logic o_i2c_mode,
   input wire logic o_master,
   input wire logic o_sample_at_end,
   input wire logic o_launch_rising,
   input wire logic o_slew_ctrl_en,
   input wire logic o_smbus_levels,
   input wire logic o_bit_launch,
   input wire logic o_bit_sample
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   mode_excl_a: assert property (!(o_spi_mode && o_i2c_mode))
      else $error("spi and i2c both on");
   sample_end_a: assert property (o_sample_at_end |-> o_spi_mode && o_master)
      else $error("sample at end outside spi master");
   sample_pulse_a: assert property (o_bit_sample |-> $past(o_spi_mode) && $past(o_master))
      else $error("sample pulse outside spi master");
   slew_mode_a: assert property (o_slew_ctrl_en |-> o_i2c_mode)
      else $error("slew control outside i2c");
   edge_mode_a: assert property (o_launch_rising |-> o_spi_mode)
      else $error("launch edge outside spi");
   smbus_mode_a: assert property (o_smbus_levels |-> o_i2c_mode)
      else $error("smbus levels outside i2c");
   pins_off_a: assert property (!o_pins_to_port && !$past(o_pins_to_port)
      |-> !o_bit_launch)
      else $error("launch while port off");
   launch_gap_a: assert property (o_bit_launch |=> !o_bit_launch)
      else $error("launch pulses back to back");
endmodule
bind sspx_top sspx_top_props u_props (.*);
`default_nettype wire

// >>> testbench/sspx_i2c_partner.sv
`timescale 1ns/1ns
`default_nettype none
module sspx_i2c_partner
(
   input wire logic i_clock,
   output logic     o_scl,
   output logic     o_sda
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   // Lines driven straight from scl_q and sda_q, idle high from their initial values
   assign o_scl = scl_q;
   assign o_sda = sda_q;
   task automatic step;
      repeat (3) @(posedge i_clock);
      #1;
   endtask
   // Start: sda falls, scl high; stop: sda rises, scl high
   task automatic cond(input logic stop);
      scl_q = !stop;
      sda_q = !stop;
      step();
      scl_q = 1'b1;
      step();
      sda_q = stop;
      step();
      scl_q = stop;
      step();
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_sync_serial_status_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_sync_serial_status_config import sspx_pkg::*;;
   logic i_clock = 1'b0, i_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = HSIZE_WORD;
   logic i_timer_tick = 1'b0, i_addr_update = 1'b0, i_byte_is_data = 1'b1, i_rw_bit = 1'b1;
   logic i_byte_done = 1'b0, i_byte_rx = 1'b0, i_buf_read = 1'b0, i_addr_match = 1'b0;
   logic i_nack = 1'b0;
   wire logic i_hready, i_scl, i_sda, o_hreadyout, o_hresp, o_irq;
   wire logic [31:0] o_hrdata;
   wire logic o_pins_to_port, o_spi_mode, o_i2c_mode, o_master, o_sample_at_end;
   wire logic o_launch_rising, o_slew_ctrl_en, o_smbus_levels, o_bit_launch, o_bit_sample;
   int miscompares = 0;
   int num_checks = 0;
   logic [4:0] evs [5] = '{5'h02, 5'h10, 5'h08, 5'h04, 5'h01};
   logic [7:0] exps [5] = '{8'h14, 8'h34, 8'h35, 8'h34, 8'h30};
   int n;
   int p;
   assign i_hready = o_hreadyout;
   sspx_top u_dut (.*);
   sspx_i2c_partner u_peer (.i_clock(i_clock), .o_scl(i_scl), .o_sda(i_sda));
   always #4 i_clock = ~i_clock;
   always @(posedge i_clock) i_timer_tick <= ~i_timer_tick;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge i_clock);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      do @(posedge i_clock); while (i_hready !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clock); while (i_hready !== 1'b1);
      r = o_hrdata;
      #1;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input string nm, input logic [31:0] a, e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge i_clock);
      {i_byte_done, i_byte_rx, i_buf_read, i_addr_match, i_nack} <= v;
      @(posedge i_clock);
      {i_byte_done, i_byte_rx, i_buf_read, i_addr_match, i_nack} <= 5'h0;
      #1;
   endtask
   task automatic gap;
      n = 0;
      while (o_bit_launch !== 1'b1 && n < 200)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      n = 0;
      p = 0;
      do
      begin
         @(posedge i_clock);
         #1;
         n++;
         if (o_bit_sample === 1'b1)
            p = n;
      end
      while (o_bit_launch !== 1'b1 && n < 200);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (30000) @(posedge i_clock);
      miscompares++;
      finish_test();
   end
   initial
   begin
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      rd("status", ADDR_STATUS, 32'h0);
      rd("unmapped", 32'hB0, 32'h0);
      chk("resp", {31'h0, HRESP_OKAY}, {31'h0, o_hresp});
      wr(ADDR_STATUS, 32'hFF);
      rd("status", ADDR_STATUS, 32'hC0);
      wr(ADDR_CONTROL, 32'h26);
      chk("pins", 32'h1, {31'h0, o_pins_to_port});
      chk("slew", 32'h0, {31'h0, o_slew_ctrl_en});
      chk("smbus", 32'h1, {31'h0, o_smbus_levels});
      wr(ADDR_STATUS, 32'h0);
      chk("slew", 32'h1, {31'h0, o_slew_ctrl_en});
      chk("smbus", 32'h0, {31'h0, o_smbus_levels});
      wr(ADDR_IRQ_EN, 32'h1);
      u_peer.cond(1'b0);
      rd("status", ADDR_STATUS, 32'h08);
      chk("irq", 32'h1, {31'h0, o_irq});
      wr(ADDR_IRQ_CLR, 32'h1);
      chk("irq", 32'h0, {31'h0, o_irq});
      u_peer.cond(1'b1);
      rd("status", ADDR_STATUS, 32'h10);
      rd("irq_stat", ADDR_IRQ_STAT, 32'h2);
      chk("irq", 32'h0, {31'h0, o_irq});
      for (int k = 0; k < 5; k++)
      begin
         pulse(evs[k]);
         rd("status", ADDR_STATUS, {24'h0, exps[k]});
      end
      wr(ADDR_CONTROL, 32'h06);
      rd("status", ADDR_STATUS, 32'h20);
      chk("pins", 32'h0, {31'h0, o_pins_to_port});
      u_peer.cond(1'b0);
      rd("status", ADDR_STATUS, 32'h20);
      for (int m = 0; m < 16; m++)
      begin
         wr(ADDR_CONTROL, 32'h20 | m);
         chk("spi", {31'h0, m < 6}, {31'h0, o_spi_mode});
         chk("i2c", {31'h0, m inside {6, 7, 8, 11, 14, 15}}, {31'h0, o_i2c_mode});
         if (m < 6)
            chk("master", {31'h0, m < 4}, {31'h0, o_master});
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_CONTROL, 32'h20 | (k[1] << 4));
         wr(ADDR_STATUS, k[0] << 6);
         chk("edge", {31'h0, k[0] ^ k[1]}, {31'h0, o_launch_rising});
      end
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 2; s++)
         begin
            wr(ADDR_CONTROL, 32'h20 | m);
            wr(ADDR_STATUS, s << 7);
            chk("smp", s, {31'h0, o_sample_at_end});
            gap();
            chk("period", (m == 3) ? 4 : 4 << (2 * m), n);
            if (m == 0)
               chk("sample", s ? 3 : 1, p);
         end
      wr(ADDR_CONTROL, 32'h24);
      wr(ADDR_STATUS, 32'h0);
      chk("slave", 32'h0, {31'h0, o_master});
      chk("smp", 32'h0, {31'h0, o_sample_at_end});
      wr(ADDR_CONTROL, 32'h26);
      u_peer.cond(1'b1);
      rd("status", ADDR_STATUS, 32'h30);
      @(posedge i_clock);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      rd("status", ADDR_STATUS, 32'h0);
      chk("pins", 32'h0, {31'h0, o_pins_to_port});
      finish_test();
   end
endmodule
`default_nettype wire
